// ===== rtl/ssc_sram.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_sram #(
  parameter int unsigned ADDR_W = ssc_pkg::SSC_ADDR_W
) (
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  input  wire ssc_pkg::ssc_cmd_s               cmd,
  input  wire logic [ADDR_W-1:0]               addr,
  input  wire logic                            out_en_n,
  input  wire logic                            burst_order_sel,
  input  wire logic                            output_bypass_n,
  input  wire logic                            sleep_request,
  input  wire logic [ssc_pkg::SSC_DATA_W-1:0]  dq_in,
  output logic      [ssc_pkg::SSC_DATA_W-1:0]  dq_out,
  output logic      [ssc_pkg::SSC_DATA_W-1:0]  dq_oe,
  output logic                                 asleep
);
  import ssc_pkg::*;

  localparam int unsigned DEPTH = 1 << ADDR_W;

  // ****************************************************************
  // Storage and state
  // ****************************************************************
  logic [SSC_DATA_W-1:0]  mem [DEPTH];
  ssc_op_e                op_q;
  logic                   dsel_q;
  logic [ADDR_W-1:0]      base_q;
  logic [1:0]             cnt_q;
  logic [1:0]             slp_cnt_q;
  logic                   asleep_q;
  // Write pipeline, two stages
  logic                   w1_v_q, w2_v_q;
  logic [ADDR_W-1:0]      w1_a_q, w2_a_q;
  logic [SSC_LANES-1:0]   w1_be_q, w2_be_q;
  // Read path: one access stage, then the bus register
  logic                   rd_v_q;
  logic [SSC_DATA_W-1:0]  rd_q;
  logic                   dq_drv_q;
  logic [SSC_DATA_W-1:0]  dq_q;

  // Burst address from loaded base and count
  function automatic logic [1:0] burst_lsb(input logic [1:0] base,
                                           input logic [1:0] cnt,
                                           input logic       ilv);
    burst_lsb = ilv ? (base ^ cnt) : 2'(base + cnt);
  endfunction

  // ****************************************************************
  // Command decode
  // ****************************************************************
  logic en, sel_ok, load, cont, wr_abort, do_read, do_write, do_cont;
  logic [ADDR_W-1:0] acc_addr;

  always_comb begin
    en       = ~cmd.gate_n & ~asleep_q;
    sel_ok   = ~cmd.chip_sel_first_n & cmd.chip_sel_second
               & ~cmd.chip_sel_third_n;
    load     = en & ~cmd.advance_load;
    cont     = en & cmd.advance_load;
    wr_abort = &cmd.byte_lane_enables_n;
    do_read  = load & sel_ok & cmd.we_n;
    do_write = load & sel_ok & ~cmd.we_n;
    do_cont  = cont & (op_q != SSC_OP_IDLE) & ~dsel_q;
    acc_addr = do_cont ? {base_q[ADDR_W-1:2],
                          burst_lsb(base_q[1:0], 2'(cnt_q + 2'h1),
                                    burst_order_sel)}
                       : addr;
  end

  // Burst counter and ownership; wraps to loaded value on fifth clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_q   <= SSC_OP_IDLE;
      dsel_q <= 1'b1;
      base_q <= '0;
      cnt_q  <= SSC_BURST_RST;
    end else if (load) begin
      dsel_q <= ~sel_ok;
      op_q   <= !sel_ok ? SSC_OP_IDLE
              : (cmd.we_n ? SSC_OP_READ : SSC_OP_WRITE);
      base_q <= addr;
      cnt_q  <= SSC_BURST_RST;
    end else if (do_cont) begin
      cnt_q  <= 2'(cnt_q + 2'h1);
    end
  end

  // Sleep entry after two enabled-or-not cycles of request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slp_cnt_q <= SSC_SLEEP_CNT_RST;
      asleep_q  <= 1'b0;
    end else if (!sleep_request) begin
      slp_cnt_q <= SSC_SLEEP_CNT_RST;
      asleep_q  <= 1'b0;
    end else if (slp_cnt_q < 2'(SSC_SLEEP_CYC - 1)) begin
      slp_cnt_q <= 2'(slp_cnt_q + 2'h1);
    end else begin
      asleep_q  <= 1'b1;
    end
  end

  // ****************************************************************
  // Write pipeline: flow-through uses stage one, pipelined stage two
  // ****************************************************************
  logic wr_now;
  always_comb begin
    wr_now = (do_write & ~wr_abort) |
             (do_cont & (op_q == SSC_OP_WRITE) & ~wr_abort);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w1_v_q  <= 1'b0;
      w2_v_q  <= 1'b0;
      w1_a_q  <= '0;
      w2_a_q  <= '0;
      w1_be_q <= '0;
      w2_be_q <= '0;
    end else if (en) begin
      w1_v_q  <= wr_now;
      w1_a_q  <= acc_addr;
      w1_be_q <= ~cmd.byte_lane_enables_n;
      w2_v_q  <= w1_v_q & output_bypass_n;
      w2_a_q  <= w1_a_q;
      w2_be_q <= w1_be_q;
    end
  end

  // Array update takes data at second or third edge
  logic              wv;
  logic [ADDR_W-1:0] wa;
  logic [SSC_LANES-1:0] wbe;
  always_comb begin
    wv  = output_bypass_n ? w2_v_q : w1_v_q;
    wa  = output_bypass_n ? w2_a_q : w1_a_q;
    wbe = output_bypass_n ? w2_be_q : w1_be_q;
  end

  always_ff @(posedge clk) begin
    if (en && wv) begin
      for (int i = 0; i < SSC_LANES; i++) begin
        if (wbe[i]) begin
          mem[wa][i*SSC_LANE_W +: SSC_LANE_W] <=
            dq_in[i*SSC_LANE_W +: SSC_LANE_W];
        end
      end
    end
  end

  // ****************************************************************
  // Read path and bus drive
  // ****************************************************************
  logic rd_now;
  always_comb begin
    rd_now = do_read | (do_cont & (op_q == SSC_OP_READ));
  end

  // Access stage; only pipelined mode reads the bus from this stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_v_q   <= 1'b0;
      rd_q     <= '0;
    end else if (asleep_q) begin
      rd_v_q   <= 1'b0;
    end else if (en) begin
      rd_v_q   <= rd_now;
      rd_q     <= mem[acc_addr];
    end
  end

  // Bus source: flow-through takes the array straight into the bus
  // register, pipelined takes the access stage one edge later
  logic          drv_d;
  logic [SSC_DATA_W-1:0] dat_d;
  always_comb begin
    drv_d = output_bypass_n ? rd_v_q : rd_now;
    dat_d = output_bypass_n ? rd_q : mem[acc_addr];
  end

  // Drive follows read beats only, so a write leaves the bus free
  // without any turnaround cycle; a stalled edge keeps the bus as is unless sleep is being entered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_drv_q <= 1'b0;
      dq_q     <= '0;
    end else if (asleep_q || sleep_request && slp_cnt_q != 2'h0) begin
      dq_drv_q <= 1'b0;
    end else if (en) begin
      dq_drv_q <= drv_d;
      dq_q     <= dat_d;
    end
  end

  // Output enable pin is asynchronous: gate the registered drive
  always_comb begin
    dq_out = dq_q;
    dq_oe  = {SSC_DATA_W{dq_drv_q & ~out_en_n & ~asleep_q}};
    asleep = asleep_q;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_reset_hiz;
    @(posedge clk) disable iff (!rst_n) $rose(rst_n) |-> !dq_drv_q;
  endproperty
  a_reset_hiz: assert property (p_reset_hiz)
    else $error("bus driven right after reset");

  property p_sleep_hiz;
    @(posedge clk) disable iff (!rst_n) asleep_q |-> dq_oe == '0;
  endproperty
  a_sleep_hiz: assert property (p_sleep_hiz)
    else $error("bus driven while asleep");

  property p_sleep_entry;
    @(posedge clk) disable iff (!rst_n)
      (!sleep_request ##1 sleep_request [*3]) |-> asleep_q;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep not entered after two cycles");

  property p_stall_hold;
    @(posedge clk) disable iff (!rst_n)
      (cmd.gate_n && !asleep_q) |=> $stable(cnt_q) && $stable(base_q);
  endproperty
  a_stall_hold: assert property (p_stall_hold)
    else $error("state moved on stalled edge");

  property p_cnt_adv;
    @(posedge clk) disable iff (!rst_n)
      do_cont |=> cnt_q == 2'($past(cnt_q) + 2'h1);
  endproperty
  a_cnt_adv: assert property (p_cnt_adv)
    else $error("burst counter did not advance");

  property p_load_base;
    @(posedge clk) disable iff (!rst_n)
      load |=> base_q == $past(addr) && cnt_q == 2'h0;
  endproperty
  a_load_base: assert property (p_load_base)
    else $error("counter not preloaded");

  property p_abort_nowr;
    @(posedge clk) disable iff (!rst_n)
      (do_write && wr_abort) |=> !w1_v_q;
  endproperty
  a_abort_nowr: assert property (p_abort_nowr)
    else $error("aborted write queued");

  property p_desel_hiz;
    @(posedge clk) disable iff (!rst_n)
      (load && !sel_ok) |=> !rd_v_q;
  endproperty
  a_desel_hiz: assert property (p_desel_hiz)
    else $error("read after deselect");

  property p_cont_after_desel;
    @(posedge clk) disable iff (!rst_n) (cont && dsel_q) |=> !rd_v_q && !w1_v_q;
  endproperty
  a_cont_after_desel: assert property (p_cont_after_desel)
    else $error("deselect continue did an access");

  property p_pipe_latency;
    @(posedge clk) disable iff (!rst_n)
      (do_read && output_bypass_n && !sleep_request)
        ##1 (!cmd.gate_n && !asleep_q && output_bypass_n && !sleep_request)
        |=> dq_drv_q;
  endproperty
  a_pipe_latency: assert property (p_pipe_latency)
    else $error("pipelined read data late");

  // ****************************************************************
  // Further checks on latency, bus drive, write abort, counter and sleep
  // ****************************************************************
  // Flow-through data must be on the bus right after the address edge
  property p_flow_latency;
    @(posedge clk) disable iff (!rst_n)
      (do_read && !output_bypass_n && !sleep_request) |=> dq_drv_q;
  endproperty
  a_flow_latency: assert property (p_flow_latency)
    else $error("flow-through read data late");

  // While write data is taken the device must not fight the controller
  property p_write_no_drive;
    @(posedge clk) disable iff (!rst_n) wv |-> !dq_drv_q;
  endproperty
  a_write_no_drive: assert property (p_write_no_drive)
    else $error("bus driven during write data");

  // The fifth access of a burst reuses the loaded address
  property p_cnt_wrap;
    @(posedge clk) disable iff (!rst_n)
      (do_cont && cnt_q == 2'h3) |=> cnt_q == 2'h0;
  endproperty
  a_cnt_wrap: assert property (p_cnt_wrap)
    else $error("burst counter did not wrap");

  // Only a load or a valid continue may move the counter
  property p_cnt_hold;
    @(posedge clk) disable iff (!rst_n)
      (!do_cont && !load) |=> $stable(cnt_q);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold)
    else $error("burst counter moved without continue");

  // A write continue with no lane enabled must not queue anything
  property p_abort_cont;
    @(posedge clk) disable iff (!rst_n)
      (do_cont && op_q == SSC_OP_WRITE && wr_abort) |=> !w1_v_q;
  endproperty
  a_abort_cont: assert property (p_abort_cont)
    else $error("aborted continue write queued");

  // Releasing the request wakes the device on the next edge
  property p_sleep_exit;
    @(posedge clk) disable iff (!rst_n) !sleep_request |=> !asleep_q;
  endproperty
  a_sleep_exit: assert property (p_sleep_exit)
    else $error("device stayed asleep");

  // Commands given while asleep leave the burst state alone
  property p_sleep_frozen;
    @(posedge clk) disable iff (!rst_n)
      asleep_q |=> $stable(base_q) && $stable(op_q);
  endproperty
  a_sleep_frozen: assert property (p_sleep_frozen)
    else $error("command taken while asleep");

  // Output enable high always wins over a pending read beat
  property p_oe_gate;
    @(posedge clk) disable iff (!rst_n) out_en_n |-> dq_oe == '0;
  endproperty
  a_oe_gate: assert property (p_oe_gate)
    else $error("bus driven with output enable high");

  c_read:   cover property (@(posedge clk) disable iff (!rst_n) do_read);
  c_write:  cover property (@(posedge clk) disable iff (!rst_n) wv);
  c_wrap:   cover property (@(posedge clk) disable iff (!rst_n)
                            do_cont && cnt_q == 2'h3);
  c_sleep:  cover property (@(posedge clk) disable iff (!rst_n) $rose(asleep_q));
  c_flow:   cover property (@(posedge clk) disable iff (!rst_n)
                            do_read && !output_bypass_n);

endmodule // ssc_sram
`default_nettype wire

// ===== rtl/ssc_pkg.sv
// Functional notes
// - Load-low, write-high, all selects active: start read burst at pin address.
// - Load-low, write-low, selects active: begin write burst at pin address.
// - Load-high continues current burst at counter address; select and write ignored.
// - Load-low with any select inactive deselects; data bus high impedance.
// - Deselect-continue only after deselect; outputs stay high impedance.
// - Write with all byte enables high is a no-operation.
// - Read with output enable high is a dummy read; bus stays undriven.
// - Output drivers switch off during write cycles automatically.
// - Clock gate high: edge ignored, all state held, bus state kept; sleep entry still counts and drops the bus drive.
// - All outputs high impedance from reset until a read drives them.
// - Two-bit burst counter preloaded from pin address at burst start.
// - Counter advances on every burst-continue cycle and no other.
// - Order select low: linear sequence, increment modulo four.
// - Order select high: loaded value XOR count, interleaved.
// - After four accesses counter returns to loaded value on fifth clock.
// - Bypass select low: flow-through; high: pipelined output register.
// - Sleep input high: asleep after two cycles, state preserved.
// - Asleep: deselected, inputs ignored, outputs high impedance.
// - Pipelined write data is taken at the third rising edge.
// - Flow-through write data is taken at the second rising edge.
// - Pipelined read data one edge after flow-through read data.
// - Each active-low byte enable selects one byte lane for writing.
package ssc_pkg;

  // ****************************************************************
  // Sizes and timing
  // ****************************************************************
  localparam int unsigned SSC_ADDR_W      = 10;
  localparam int unsigned SSC_LANES       = 4;
  localparam int unsigned SSC_LANE_W      = 9;
  localparam int unsigned SSC_DATA_W      = SSC_LANES * SSC_LANE_W;
  localparam int unsigned SSC_BURST_W     = 2;
  localparam int unsigned SSC_SLEEP_CYC   = 2;
  localparam logic [1:0]  SSC_SLEEP_CNT_RST = 2'h0;
  localparam logic [1:0]  SSC_BURST_RST   = 2'h0;

  // Burst ownership of the current cycle
  typedef enum logic [1:0] {
    SSC_OP_IDLE,
    SSC_OP_READ,
    SSC_OP_WRITE
  } ssc_op_e;

  // Sampled command pins travel together
  typedef struct packed {
    logic                  gate_n;
    logic                  advance_load;
    logic                  we_n;
    logic [SSC_LANES-1:0]  byte_lane_enables_n;
    logic                  chip_sel_first_n;
    logic                  chip_sel_second;
    logic                  chip_sel_third_n;
  } ssc_cmd_s;

endpackage

// ===== bench/ssc_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Shared data bus
// ****************
module ssc_bus_model
  import ssc_pkg::*;
(
  input  wire logic                           clk,
  input  wire logic [ssc_pkg::SSC_DATA_W-1:0] dev_data,
  input  wire logic [ssc_pkg::SSC_DATA_W-1:0] dev_oe,
  input  wire logic [ssc_pkg::SSC_DATA_W-1:0] ctl_data,
  input  wire logic                           ctl_drv,
  output logic      [ssc_pkg::SSC_DATA_W-1:0] bus,
  output logic                                clash
);
  logic [SSC_DATA_W-1:0] last_q = '0;
  // No keeper: a released bus shows the inverse of its last value, so
  // stale data never passes for a fresh write
  always_comb begin
    bus = ~last_q;
    if (ctl_drv) bus = ctl_data;
    else if (dev_oe[0]) bus = dev_data;
  end
  // Both parties driving at once
  assign clash = ctl_drv & dev_oe[0];
  always @(posedge clk) last_q <= bus;
endmodule // ssc_bus_model
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ssc_pkg::*;
  localparam int AW = SSC_ADDR_W;
  localparam int DW = SSC_DATA_W;
  logic          clk, rst_n, out_en_n, burst_order_sel, output_bypass_n;
  logic          sleep_request, asleep, ctl_drv, clash, en_edge;
  logic          stall_on, asleep_m;
  ssc_cmd_s      cmd;
  logic [AW-1:0] addr, base;
  logic [1:0]    cnt;
  logic [DW-1:0] dq_in, dq_out, dq_oe, ctl_data, last_out, last_oe;
  logic [DW-1:0] ref_mem [0:63];
  logic [DW-1:0] pdat [0:1];
  logic          pd [0:1];
  logic [DW-1:0] exp_q [$];
  logic [DW-1:0] got_q [$];
  int            kind, fails, n_compared, cycles, seed;
  int            lat [0:1];

  ssc_sram #(.ADDR_W(AW)) dut_u (
    .clk(clk), .rst_n(rst_n), .cmd(cmd), .addr(addr), .out_en_n(out_en_n),
    .burst_order_sel(burst_order_sel), .output_bypass_n(output_bypass_n),
    .sleep_request(sleep_request), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .asleep(asleep));
  ssc_bus_model bus_u (
    .clk(clk), .dev_data(dq_out), .dev_oe(dq_oe), .ctl_data(ctl_data),
    .ctl_drv(ctl_drv), .bus(dq_in), .clash(clash));

  // ****************
  // Helpers
  // ****************
  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      fails++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // One command cycle; the model tracks the burst and schedules write data
  task automatic issue(input int op, input logic [AW-1:0] a,
                       input logic [3:0] be_n, input logic [2:0] desel);
    logic [2:0]    sel;
    logic [AW-1:0] ea;
    logic [DW-1:0] wd;
    logic [63:0]   r;
    sel = (op == 3) ? 3'($random(seed)) : desel;
    r = {$random(seed), $random(seed)};
    wd = r[DW-1:0];
    if (stall_on && ($random(seed) & 3) == 0) begin
      @(posedge clk);
      cmd <= {1'b1, 9'($random(seed))};
      addr <= AW'($random(seed));
    end
    @(posedge clk);
    cmd <= '{gate_n: 1'b0, advance_load: (op == 3),
             we_n: (op == 2) ? 1'b0 : (op == 1) ? 1'b1 : 1'($random(seed)),
             byte_lane_enables_n: be_n, chip_sel_first_n: sel[0],
             chip_sel_second: !sel[1], chip_sel_third_n: sel[2]};
    addr <= a;
    ctl_drv <= pd[0];
    ctl_data <= pdat[0];
    pd[0] = pd[1];
    pdat[0] = pdat[1];
    pd[1] = 1'b0;
    if (asleep_m) return;
    if (op == 0) kind = 0;
    else if (op < 3) begin
      kind = op;
      base = a;
      cnt = 2'd0;
    end else if (kind != 0) cnt++;
    ea = {base[AW-1:2], burst_order_sel ? base[1:0] ^ cnt : base[1:0] + cnt};
    if (kind == 1 && !out_en_n) exp_q.push_back(ref_mem[ea[5:0]]);
    if (kind == 2) begin
      for (int i = 0; i < SSC_LANES; i++)
        if (!be_n[i]) ref_mem[ea[5:0]][i*SSC_LANE_W +: SSC_LANE_W] =
          wd[i*SSC_LANE_W +: SSC_LANE_W];
      pd[output_bypass_n] = 1'b1;
      pdat[output_bypass_n] = wd;
    end
  endtask

  task automatic idle(input int n);
    repeat (n) issue(0, '0, 4'hF, 3'b001);
  endtask

  // Let the pipeline empty, then compare beats in order
  task automatic drain();
    idle(6);
    check(got_q.size() == exp_q.size(), "beat count");
    while (got_q.size() > 0 && exp_q.size() > 0)
      check(got_q.pop_front() === exp_q.pop_front(), "read data");
    got_q = {};
    exp_q = {};
  endtask

  // ****************
  // Clock, monitor
  // ****************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // A bus held through wait states is one beat, not several
  always @(posedge clk) begin
    en_edge <= !cmd.gate_n;
    cycles++;
    if (cycles == 4000) begin
      fails++;
      print_verdict();
    end
  end
  always @(negedge clk) begin
    if (rst_n && en_edge && dq_oe[0] === 1'b1) got_q.push_back(dq_out);
    if (rst_n && !en_edge)
      check(dq_oe === last_oe && dq_out === last_out, "stall moved");
    if (clash === 1'b1) check(1'b0, "bus contention");
    last_oe <= dq_oe;
    last_out <= dq_out;
  end

  // ****************
  // Scenarios
  // ****************
  initial begin
    seed = 32'h814ca723;
    rst_n = 1'b0;
    cmd = '0;
    addr = '0;
    out_en_n = 1'b0;
    burst_order_sel = 1'b0;
    output_bypass_n = 1'b1;
    sleep_request = 1'b0;
    ctl_drv = 1'b0;
    ctl_data = '0;
    pd = '{1'b0, 1'b0};
    stall_on = 1'b1;
    asleep_m = 1'b0;
    repeat (10) begin
      @(posedge clk);
      check(dq_oe === '0, "drive in reset");
    end
    rst_n <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      output_bypass_n <= 1'(1 - m);
      idle(2);
      for (int a = 0; a < 64; a++) issue(2, AW'(a), 4'h0, 3'b0);
      stall_on = 1'b0;
      idle(4);
      issue(1, 10'd5, 4'h0, 3'b0);
      idle(1);
      lat[m] = 0;
      while (dq_oe[0] !== 1'b1 && lat[m] < 8) begin
        @(negedge clk);
        lat[m]++;
      end
      stall_on = 1'b1;
      for (int o = 0; o < 2; o++) begin
        burst_order_sel <= 1'(o);
        issue(2, AW'($random(seed) & 63), 4'h0, 3'b0);
        repeat (5) issue(3, '0, 4'($random(seed)), 3'b0);
        idle(3);
        issue(1, AW'($random(seed) & 63), 4'h0, 3'b0);
        repeat (6) issue(3, '0, 4'h0, 3'b0);
      end
      issue(2, AW'($random(seed) & 63), 4'hF, 3'b0);
      for (int i = 0; i < 3; i++) begin
        issue(0, '0, 4'h0, 3'(1 << i));
        issue(3, '0, 4'h0, 3'b0);
      end
      drain();
      out_en_n <= 1'b1;
      idle(1);
      issue(1, 10'd9, 4'h0, 3'b0);
      repeat (2) issue(3, '0, 4'h0, 3'b0);
      idle(6);
      out_en_n <= 1'b0;
      drain();
      sleep_request <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      check(asleep === 1'b0, "asleep early");
      @(negedge clk);
      check(asleep === 1'b1, "not asleep");
      asleep_m = 1'b1;
      issue(2, 10'd7, 4'h0, 3'b0);
      idle(2);
      check(asleep === 1'b1 && dq_oe === '0, "sleep drive");
      sleep_request <= 1'b0;
      idle(3);
      asleep_m = 1'b0;
      check(asleep === 1'b0, "still asleep");
      for (int a = 0; a < 64; a++) issue(1, AW'(a), 4'h0, 3'b0);
      drain();
    end
    check(lat[0] == lat[1] + 1, "read latency");
    print_verdict();
  end
endmodule // tb
`default_nettype wire
